// [common/lrpgc_pkg.sv]
// constants, register map and field layout of the lcd refresh, pan, gray and contrast block
// Behaviour
// RL1: frame period = (12+width+adjust)*height*(div+1) clocks
// RL2: adjust value is 10 bits, upper bits zero
// RL3: picture shifts left by panning offset pixels
// RL4: panning same in black-white and gray modes
// RL5: retired frame modulation byte stores nothing
// RL6: lowest and highest gray codes fixed black/white; code gives lowest code white, highest code black
// RL7: map upper nibble sets one mid gray
// RL8: map lower nibble sets other mid gray
// RL9: source select: line, pixel, lcd clock; 11 reserved
// RL10: contrast counter spans 256 input clocks
// RL11: contrast enable bit 8 turns pwm on/off
// RL12: 8-bit pulse width sets contrast duty
// RL13: pixel clock = lcd clock/(divider+1), zero bypasses
// RL14: controller runs only while enable bit 7 set
// RL15: contrast high first width counts of period
package lrpgc_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 26;
  localparam int IDX_W = 24;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SCREEN_W = 24'hfffa08;
  localparam logic [IDX_W-1:0] IDX_SCREEN_H = 24'hfffa0a;
  localparam logic [IDX_W-1:0] IDX_PIX_DIV = 24'hfffa25;
  localparam logic [IDX_W-1:0] IDX_CLK_CTRL = 24'hfffa27;
  localparam logic [IDX_W-1:0] IDX_REFRESH = 24'hfffa28;
  localparam logic [IDX_W-1:0] IDX_PANNING = 24'hfffa2d;
  localparam logic [IDX_W-1:0] IDX_RETIRED = 24'hfffa31;
  localparam logic [IDX_W-1:0] IDX_GRAY_MAP = 24'hfffa33;
  localparam logic [IDX_W-1:0] IDX_CONTRAST = 24'hfffa36;

  // ==========================================================
  // values after reset
  localparam logic [9:0] RST_SCREEN_W = 10'h010;
  localparam logic [9:0] RST_SCREEN_H = 10'h008;
  localparam logic [5:0] RST_PIX_DIV = 6'h00;
  localparam logic [7:0] RST_CLK_CTRL = 8'h00;
  localparam logic [9:0] RST_REFRESH = 10'h000;
  localparam logic [3:0] RST_PANNING = 4'h0;
  localparam logic [7:0] RST_GRAY_MAP = 8'h84;
  localparam logic [10:0] RST_CONTRAST = 11'h000;

  // ==========================================================
  // field positions
  localparam int POS_CTRL_EN = 7;
  localparam int POS_CON_EN = 8;
  localparam int POS_SRC_LO = 9;

  // ==========================================================
  // line timing and shading constants
  localparam logic [11:0] LINE_OVERHEAD = 12'h00c;
  localparam logic [3:0] SHADE_WHITE = 4'h0;
  localparam logic [3:0] SHADE_BLACK = 4'hf;

  // contrast counter input select codes
  typedef enum logic [1:0] {
    LRPGC_SRC_LINE = 2'h0,
    LRPGC_SRC_PIXEL = 2'h1,
    LRPGC_SRC_LCD = 2'h2,
    LRPGC_SRC_RSVD = 2'h3
  } lrpgc_src_t;

endpackage : lrpgc_pkg

// [src/lrpgc_pwm.sv]
// contrast pulse-width modulator with a 256-count period
`timescale 1ns/100ps
module lrpgc_pwm
  import lrpgc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic enable,
  input wire logic tick,
  input wire logic [WIDTH-1:0] width,
  // output to the contrast circuit
  output logic out
);

  // ==========================================================
  // period counter, wraps naturally after 2**WIDTH ticks
  logic [WIDTH-1:0] cnt;
  wire next_out = enable && (cnt < width); // [RL15] [RL12]

  // counter held at zero while off so each enable starts a clean period
  always_ff @(posedge clk) begin
    if (reset || !enable) begin // [RL11]
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + 1'b1; // [RL10]
    end
  end

  // registered output keeps the panel line glitch free
  always_ff @(posedge clk) begin
    if (reset) begin
      out <= 1'b0;
    end else begin
      out <= next_out;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pwm_off: assert property (!enable |=> !out) // [RL11]
    else $error("contrast output high while disabled");
  a_pwm_wrap: assert property (enable && tick && cnt == '1 ##1 enable |-> cnt == '0) // [RL10]
    else $error("contrast counter did not wrap after 256 counts");
  a_pwm_duty: assert property (enable && cnt == '0 && width != '0 |=> out) // [RL15]
    else $error("contrast output low at period start with nonzero width");
  a_pwm_tail: assert property (enable && cnt >= width |=> !out) // [RL12]
    else $error("contrast output high past pulse width");

endmodule : lrpgc_pwm

// [src/lrpgc_top.sv]
// lcd refresh timing, panning, gray mapping and contrast control with an avalon slave
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
module lrpgc_top
  import lrpgc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pixel stream from the fetch logic
  input wire logic [1:0] pix_code,
  // panel timing
  output logic pixel_tick,
  output logic line_pulse,
  output logic frame_pulse,
  output logic pixel_active,
  output logic [9:0] pixel_column,
  // shading and contrast
  output logic [3:0] pixel_shade,
  output logic contrast_out
);

  // ==========================================================
  // registers
  logic [9:0] screen_width_px; // pixels per line
  logic [9:0] screen_height_px; // lines per frame
  logic [5:0] pixel_divider_field; // pixel clock divider
  logic [7:0] clocking_control; // bit 7 enable, rest scratch
  logic [9:0] idle_extend_value; // refresh adjustment
  logic [3:0] pan_shift_code; // left shift in pixels
  logic [7:0] gray_level_map; // two mid gray densities
  logic [10:0] contrast_pwm_control; // source, enable, width

  // ==========================================================
  // bus decode
  wire [IDX_W-1:0] idx = avs_address[ADDR_W-1:2];
  wire req = avs_read | avs_write;
  wire accept = req & avs_waitrequest; // first cycle of a request
  wire commit = req & ~avs_waitrequest; // edge at which master completes
  wire wr_en = commit & avs_write;
  wire be0 = avs_byteenable[0];
  wire be1 = avs_byteenable[1];
  wire [7:0] wd0 = avs_writedata[7:0];
  wire [7:0] wd1 = avs_writedata[15:8];

  wire hit_w = idx == IDX_SCREEN_W;
  wire hit_h = idx == IDX_SCREEN_H;
  wire hit_div = idx == IDX_PIX_DIV;
  wire hit_ctl = idx == IDX_CLK_CTRL;
  wire hit_rra = idx == IDX_REFRESH;
  wire hit_pan = idx == IDX_PANNING;
  wire hit_ret = idx == IDX_RETIRED;
  wire hit_map = idx == IDX_GRAY_MAP;
  wire hit_con = idx == IDX_CONTRAST;

  // readback mux; unmapped and retired locations read zero
  wire [31:0] rd_mux =
    hit_w ? {22'h0, screen_width_px} :
    hit_h ? {22'h0, screen_height_px} :
    hit_div ? {26'h0, pixel_divider_field} :
    hit_ctl ? {24'h0, clocking_control} :
    hit_rra ? {22'h0, idle_extend_value} : // [RL2]
    hit_pan ? {28'h0, pan_shift_code} :
    hit_map ? {24'h0, gray_level_map} :
    hit_con ? {21'h0, contrast_pwm_control} :
    32'h0; // [RL5]

  // one wait state: decode in the first cycle, complete in the next
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~accept;
    end
  end

  // read data captured while waitrequest still stands high
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if (accept && avs_read) begin
      avs_readdata <= rd_mux;
    end
  end

  // ==========================================================
  // register writes, low lanes only; the retired byte has no storage
  always_ff @(posedge clk) begin
    if (reset) begin
      screen_width_px <= RST_SCREEN_W;
      screen_height_px <= RST_SCREEN_H;
      pixel_divider_field <= RST_PIX_DIV;
      clocking_control <= RST_CLK_CTRL; // [RL14]
      idle_extend_value <= RST_REFRESH;
      pan_shift_code <= RST_PANNING;
      gray_level_map <= RST_GRAY_MAP;
      contrast_pwm_control <= RST_CONTRAST;
    end else if (wr_en) begin
      if (hit_w && be0) screen_width_px[7:0] <= wd0;
      if (hit_w && be1) screen_width_px[9:8] <= wd1[1:0];
      if (hit_h && be0) screen_height_px[7:0] <= wd0;
      if (hit_h && be1) screen_height_px[9:8] <= wd1[1:0];
      if (hit_div && be0) pixel_divider_field <= wd0[5:0];
      if (hit_ctl && be0) clocking_control <= wd0;
      // upper bits 15-10 are not stored [RL2]
      if (hit_rra && be0) idle_extend_value[7:0] <= wd0;
      if (hit_rra && be1) idle_extend_value[9:8] <= wd1[1:0];
      if (hit_pan && be0) pan_shift_code <= wd0[3:0];
      if (hit_map && be0) gray_level_map <= wd0;
      if (hit_con && be0) contrast_pwm_control[7:0] <= wd0;
      if (hit_con && be1) contrast_pwm_control[10:8] <= wd1[2:0];
    end
  end

  // ==========================================================
  // control fields
  wire run = clocking_control[POS_CTRL_EN]; // [RL14]
  wire con_en = contrast_pwm_control[POS_CON_EN]; // [RL11]
  wire [1:0] src_code = contrast_pwm_control[POS_SRC_LO+1:POS_SRC_LO];
  wire [7:0] contrast_pulse_width = contrast_pwm_control[7:0]; // [RL12]

  // ==========================================================
  // pixel clock enable, line and frame counters
  logic [5:0] div_cnt;
  logic [11:0] x_cnt;
  logic [9:0] y_cnt;

  // each line carries 12 overhead pixels plus the idle extension
  wire [11:0] line_len = LINE_OVERHEAD + {2'h0, screen_width_px}
    + {2'h0, idle_extend_value}; // [RL1] [RL2]
  wire [11:0] line_last = line_len - 12'h001;
  wire [9:0] y_last = screen_height_px - 10'h001;
  wire pix_en = run && (div_cnt == pixel_divider_field); // [RL13]
  wire line_end = pix_en && (x_cnt == line_last); // [RL1]
  wire frame_end = line_end && (y_cnt == y_last); // [RL1]

  // divider: value zero gives an enable every lcd clock
  always_ff @(posedge clk) begin
    if (reset || !run || pix_en) begin // [RL13] [RL14]
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // horizontal position in pixel clocks
  always_ff @(posedge clk) begin
    if (reset || !run) begin // [RL14]
      x_cnt <= 12'h000;
    end else if (pix_en) begin
      x_cnt <= (x_cnt == line_last) ? 12'h000 : x_cnt + 12'h001; // [RL1]
    end
  end

  // vertical position in lines
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      y_cnt <= 10'h000;
    end else if (line_end) begin
      y_cnt <= (y_cnt == y_last) ? 10'h000 : y_cnt + 10'h001; // [RL1]
    end
  end

  // ==========================================================
  // panning: the fetched column runs ahead by the shift code, so the
  // picture moves left; no mode input is consulted on purpose
  wire [9:0] next_column = x_cnt[9:0] + {6'h0, pan_shift_code}; // [RL3] [RL4]
  wire next_active = run && (x_cnt < {2'h0, screen_width_px});

  // timing strobes registered so every output leaves a flip-flop
  always_ff @(posedge clk) begin
    if (reset) begin
      pixel_tick <= 1'b0;
      line_pulse <= 1'b0;
      frame_pulse <= 1'b0;
      pixel_active <= 1'b0;
      pixel_column <= 10'h000;
    end else begin
      pixel_tick <= pix_en;
      line_pulse <= line_end;
      frame_pulse <= frame_end;
      pixel_active <= next_active;
      pixel_column <= next_column; // [RL3]
    end
  end

  // ==========================================================
  // gray mapping: ends are fixed, middles come from the map nibbles
  wire [3:0] gray_density_a = gray_level_map[3:0]; // [RL8]
  wire [3:0] gray_density_b = gray_level_map[7:4]; // [RL7]
  wire [3:0] next_shade =
    (pix_code == 2'h0) ? SHADE_WHITE : // [RL6]
    (pix_code == 2'h1) ? gray_density_a : // [RL8]
    (pix_code == 2'h2) ? gray_density_b : // [RL7]
    SHADE_BLACK; // [RL6]

  // shade follows the code by one clock
  always_ff @(posedge clk) begin
    if (reset) begin
      pixel_shade <= SHADE_WHITE;
    end else begin
      pixel_shade <= next_shade;
    end
  end

  // ==========================================================
  // contrast counter input; the reserved code stalls the counter
  wire pwm_tick =
    (src_code == LRPGC_SRC_LINE) ? line_end :
    (src_code == LRPGC_SRC_PIXEL) ? pix_en :
    (src_code == LRPGC_SRC_LCD) ? 1'b1 :
    1'b0; // [RL9]

  lrpgc_pwm #(
    .WIDTH(8)
  ) u_pwm (
    .clk(clk),
    .reset(reset),
    .enable(con_en),
    .tick(pwm_tick),
    .width(contrast_pulse_width),
    .out(contrast_out)
  );

  // ==========================================================
  // checker helpers: clocks per line while configuration is steady
  logic [17:0] lc_cnt;
  logic cfg_steady;
  // widen before adding one, so divider 63 gives 64 instead of wrapping to 0
  wire [17:0] div_n = {12'h0, pixel_divider_field} + 18'h00001;
  wire [17:0] line_clocks = {6'h0, line_len} * div_n;

  // counts clocks since the last line pulse
  always_ff @(posedge clk) begin
    if (reset || !run || line_end) begin
      lc_cnt <= 18'h0;
    end else begin
      lc_cnt <= lc_cnt + 18'h1;
    end
  end

  // steady from the first line end after the last register write
  always_ff @(posedge clk) begin
    if (reset || !run || wr_en) begin
      cfg_steady <= 1'b0;
    end else if (line_end) begin
      cfg_steady <= 1'b1;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_read_accept;
    avs_read && avs_waitrequest;
  endsequence

  sequence s_div_one;
    run && pixel_divider_field == 6'h01 && !wr_en;
  endsequence

  a_line_period: assert property (line_end && cfg_steady |-> lc_cnt + 18'h1 == line_clocks) // [RL1]
    else $error("line length differs from overhead+width+adjust times divider");
  a_frame_line: assert property (frame_pulse |-> line_pulse) // [RL1]
    else $error("frame pulse without closing line pulse");
  a_rra_upper: assert property (s_read_accept ##1 hit_rra |-> avs_readdata[15:10] == 6'h0) // [RL2]
    else $error("refresh adjust upper bits read nonzero");
  a_pan_start: assert property ($rose(pixel_active) |-> pixel_column == {6'h0, $past(pan_shift_code)}) // [RL3]
    else $error("first visible column is not the pan offset");
  a_retired_zero: assert property ((s_read_accept and hit_ret) |=> avs_readdata == 32'h0) // [RL5]
    else $error("retired location read nonzero");
  a_gray_ends: assert property (pix_code == 2'h3 |=> pixel_shade == SHADE_BLACK) // [RL6]
    else $error("highest code not full black");
  a_gray_white: assert property (pix_code == 2'h0 |=> pixel_shade == SHADE_WHITE) // [RL6]
    else $error("lowest code not full white");
  a_gray_mid: assert property (pix_code == 2'h2 |=> pixel_shade == $past(gray_level_map[7:4])) // [RL7]
    else $error("mid gray b not from upper nibble");
  a_gray_low: assert property (pix_code == 2'h1 |=> pixel_shade == $past(gray_level_map[3:0])) // [RL8]
    else $error("mid gray a not from lower nibble");
  a_src_rsvd: assert property (src_code == LRPGC_SRC_RSVD |-> !pwm_tick) // [RL9]
    else $error("reserved source advanced contrast counter");
  a_pix_div: assert property (pix_en ##1 s_div_one |-> !pix_en ##1 pix_en) // [RL13]
    else $error("divider one does not halve the pixel clock");
  a_off_quiet: assert property (!run ##1 !run |-> !pixel_tick && !line_pulse) // [RL14]
    else $error("timing strobes while controller disabled");

endmodule : lrpgc_top

// [tb/lrpgc_panel_model.sv]
// panel and contrast circuit model that measures what the controller drives
`timescale 1ns/100ps
module lrpgc_panel_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // panel timing
  input wire logic line_pulse,
  input wire logic frame_pulse,
  input wire logic pixel_active,
  input wire logic [9:0] pixel_column,
  // contrast drive
  input wire logic contrast_out,
  // measurements: lengths in clock cycles, contrast rise count, column range
  output logic [31:0] line_len,
  output logic [31:0] frame_len,
  output logic [31:0] pwm_period,
  output logic [31:0] pwm_high,
  output logic [31:0] pwm_rises,
  output logic [9:0] col_min,
  output logic [9:0] col_max
);
  // ==========================================================
  // timestamps
  logic [31:0] cyc; // free cycle count
  logic [31:0] t_line, t_frame, t_rise; // last event times
  logic [9:0] lo, hi; // column range of the frame in progress
  logic last_con; // contrast level one cycle ago

  // a real panel only sees edges, so every length and time is a gap between events
  always_ff @(posedge clk) begin
    if (reset) begin
      cyc <= '0;
      t_line <= '0;
      t_frame <= '0;
      t_rise <= '0;
      pwm_rises <= '0;
      last_con <= 1'b0;
      lo <= 10'h3ff;
      hi <= 10'h000;
    end else begin
      cyc <= cyc + 1;
      last_con <= contrast_out;
      // line and frame lengths
      if (line_pulse) begin
        line_len <= cyc - t_line;
        t_line <= cyc;
      end
      // the range is latched per frame, so a partial first frame is reported until the next frame pulse
      if (frame_pulse) begin
        frame_len <= cyc - t_frame;
        t_frame <= cyc;
        col_min <= lo;
        col_max <= hi;
        lo <= 10'h3ff;
        hi <= 10'h000;
      end else if (pixel_active) begin
        if (pixel_column < lo) lo <= pixel_column;
        if (pixel_column > hi) hi <= pixel_column;
      end
      // contrast period and high time
      if (contrast_out && !last_con) begin
        pwm_period <= cyc - t_rise;
        t_rise <= cyc;
        pwm_rises <= pwm_rises + 1;
      end
      if (!contrast_out && last_con) pwm_high <= cyc - t_rise;
    end
  end
endmodule : lrpgc_panel_model

// [tb/tb_lrpgc_top.sv]
// self-checking bench for the lcd refresh, pan, gray and contrast block
`timescale 1ns/100ps
module tb_lrpgc_top import lrpgc_pkg::*;;
  // ==========================================================
  // signals
  logic clk, reset, avs_read, avs_write, avs_waitrequest; // bus control
  logic [ADDR_W-1:0] avs_address; // byte address
  logic [31:0] avs_writedata, avs_readdata; // bus data
  logic [3:0] avs_byteenable; // lane enables
  logic [1:0] pix_code; // pixel gray code
  logic pixel_tick, line_pulse, frame_pulse, pixel_active, contrast_out; // panel
  logic [9:0] pixel_column; // shown column
  logic [3:0] pixel_shade; // shade density
  logic [31:0] line_len, frame_len, pwm_period, pwm_high, pwm_rises; // measured
  logic [9:0] col_min, col_max; // measured column range
  int fails = 0; // mismatches
  int n_tests = 0; // comparisons
  logic [31:0] seed = 32'h08ff741a; // random state

  lrpgc_top DUT (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pix_code, .pixel_tick, .line_pulse,
    .frame_pulse, .pixel_active, .pixel_column, .pixel_shade, .contrast_out);
  lrpgc_panel_model panel (.clk, .reset, .line_pulse, .frame_pulse, .pixel_active,
    .pixel_column, .contrast_out, .line_len, .frame_len, .pwm_period, .pwm_high,
    .pwm_rises, .col_min, .col_max);

  // ==========================================================
  // clock and watchdog; the run needs about 20k cycles
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    conclude();
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected density: end codes fixed, middle codes from the map
  function automatic logic [3:0] shade(input logic [1:0] c, input logic [7:0] m);
    case (c)
      2'h0: return 4'h0;
      2'h1: return m[3:0];
      2'h2: return m[7:4];
      default: return 4'hf;
    endcase
  endfunction : shade

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [15:0] wd,
    input logic [3:0] be, output logic [15:0] rd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // one idle edge so the next request never lands in the release step
    @(posedge clk);
  endtask : bus

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, 4'hf, q);
    chk({16'h0000, q}, {16'h0000, exp});
  endtask : rdchk

  // stop the timing, load geometry, start again so counters restart from 0
  task automatic cfg(input logic [15:0] w, h, r, d, p);
    logic [15:0] q;
    bus(1'b1, IDX_CLK_CTRL, 16'h0000, 4'hf, q);
    bus(1'b1, IDX_SCREEN_W, w, 4'hf, q);
    bus(1'b1, IDX_SCREEN_H, h, 4'hf, q);
    bus(1'b1, IDX_REFRESH, r, 4'hf, q);
    bus(1'b1, IDX_PIX_DIV, d, 4'hf, q);
    bus(1'b1, IDX_PANNING, p, 4'hf, q);
    bus(1'b1, IDX_CLK_CTRL, 16'h0080, 4'hf, q);
  endtask : cfg

  task automatic conclude();
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] q, w, h, r, d, p, k, wd;
    logic [1:0] c;
    int n;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = '0;
    pix_code = 2'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset values, retired byte, unmapped place, masked fields
    rdchk(IDX_GRAY_MAP, 16'h0084);
    rdchk(IDX_PANNING, 16'h0000);
    rdchk(IDX_CONTRAST, 16'h0000);
    rdchk(IDX_CLK_CTRL, 16'h0000);
    bus(1'b1, IDX_RETIRED, 16'h00ff, 4'hf, q);
    rdchk(IDX_RETIRED, 16'h0000);
    rdchk(24'hfffa30, 16'h0000);
    bus(1'b1, IDX_REFRESH, 16'hffff, 4'hf, q);
    rdchk(IDX_REFRESH, 16'h03ff);
    bus(1'b1, IDX_REFRESH, 16'h0155, 4'h1, q);
    rdchk(IDX_REFRESH, 16'h0355);
    // scratch bits stored while the controller stays off
    bus(1'b1, IDX_CLK_CTRL, 16'h005a, 4'hf, q);
    rdchk(IDX_CLK_CTRL, 16'h005a);
    n = 0;
    repeat (200) @(posedge clk) n += (pixel_tick | line_pulse) !== 1'b0;
    chk(n, 0);
    // frame pacing and panning; first pass is the smallest geometry
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = (i == 0) ? 16'd1 : 16'd1 + seed[4:0];
      h = (i == 0) ? 16'd1 : 16'd1 + seed[6:5];
      r = (i == 0) ? 16'd0 : {12'h000, seed[10:7]};
      d = (i == 0) ? 16'd0 : {14'h0000, seed[12:11]};
      p = (i == 3) ? 16'd15 : {12'h000, seed[16:13]};
      cfg(w, h, r, d, p);
      repeat (3) @(posedge clk iff frame_pulse);
      @(posedge clk);
      k = (16'd12 + w + r) * (d + 16'd1);
      chk(line_len, k);
      chk(frame_len, k * h);
      chk(col_min, p[9:0]);
      chk(col_max, p[9:0] + w[9:0] - 10'd1);
      // a window of whole divider periods holds one tick per pixel
      n = 0;
      repeat (k * h) @(posedge clk) n += (pixel_tick === 1'b1);
      chk(n, h * (16'd12 + w + r));
    end
    // gray mapping, reset map then a random one
    for (int j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      wd = (j == 0) ? 16'h0084 : {8'h00, seed[7:0]};
      bus(1'b1, IDX_GRAY_MAP, wd, 4'hf, q);
      for (int i = 0; i < 12; i++) begin
        seed = lfsr(seed);
        c = (i < 4) ? i[1:0] : seed[1:0];
        pix_code <= c;
        @(posedge clk);
        @(posedge clk);
        chk(pixel_shade, shade(c, wd[7:0]));
      end
    end
    // contrast on the line, pixel and lcd clock sources; pixel clock every 2, line every 26 cycles
    cfg(16'd1, 16'd1, 16'd0, 16'd1, 16'd0);
    for (int s = 0; s < 3; s++) begin
      seed = lfsr(seed);
      wd = (seed[7:0] == 8'h00) ? 16'd1 : {8'h00, seed[7:0]};
      k = (s == 0) ? 16'd26 : (s == 1) ? 16'd2 : 16'd1;
      bus(1'b1, IDX_CONTRAST, {5'h00, s[1:0], 1'b1, wd[7:0]}, 4'hf, q);
      n = pwm_rises;
      while (pwm_rises < n + 3) @(posedge clk);
      chk(pwm_period, 32'd256 * k);
      chk(pwm_high, wd * k);
    end
    // enable off keeps the output low
    bus(1'b1, IDX_CONTRAST, 16'h0480, 4'hf, q);
    repeat (3) @(posedge clk);
    n = 0;
    repeat (300) @(posedge clk) n += contrast_out !== 1'b0;
    chk(n, 0);
    // reserved source must not count like the fast clock
    bus(1'b1, IDX_CONTRAST, 16'h0780, 4'hf, q);
    repeat (3) @(posedge clk);
    n = pwm_rises;
    repeat (600) @(posedge clk);
    chk(pwm_rises, n);
    conclude();
  end
endmodule : tb_lrpgc_top
